// ### shared/exec_defs.svh
/*
 * constants for the skip / table-read / exclusive-or execution unit.
 * assumes inclusion by bare name from design files.
 */
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

`define DATA_W        8
`define ROM_AW        14
`define RAM_AW        12
`define PAGE_BITS     8
`define ACC_RESET     8'h00
`define TABLE_HIGH_LATCH_RESET    8'h00
`define ZERO_BIT      0

`endif

// ### shared/exec_pkg.sv
/*
 * types for the execution unit: operation codes and carriers.
 * assumes the defs header sits beside it.
 */
`include "exec_defs.svh"
package exec_pkg;

  typedef enum logic [3:0] {
    OP_NONE           = 4'h0,
    OP_SWAP_TO_ACC    = 4'h1,
    OP_SKIP_NULL      = 4'h2,
    OP_COPY_SKIP_NULL = 4'h3,
    OP_SKIP_BIT_CLR   = 4'h4,
    OP_TABLE_CUR      = 4'h5,
    OP_TABLE_FINAL    = 4'h6,
    OP_XOR_ACC        = 4'h7,
    OP_XOR_MEM        = 4'h8,
    OP_XOR_IMM        = 4'h9
  } exec_op_t;

  typedef struct packed {
    exec_op_t              op;
    logic [`RAM_AW-1:0]    addr;
    logic [2:0]            bit_sel;
    logic [`DATA_W-1:0]    imm;
  } exec_req_t;

  typedef struct packed {
    logic                  we;
    logic [`RAM_AW-1:0]    addr;
    logic [`DATA_W-1:0]    data;
  } mem_wr_t;

endpackage

// ### core/table_rom_port.sv
/*
 * table fetch port: forms the program rom word address and registers the word.
 * assumes a synchronous rom answering one cycle after the address.
 */
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"
module table_rom_port #(
  parameter int ROM_AW    = `ROM_AW,
  parameter int PAGE_BITS = `PAGE_BITS
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  // request
  input  wire logic                 fetch,
  input  wire logic                 final_page,
  input  wire logic [ROM_AW-1:0]    pc,
  input  wire logic [PAGE_BITS-1:0] table_pointer,
  // rom side
  output logic      [ROM_AW-1:0]    rom_addr,
  input  wire logic [15:0]          rom_data,
  // result
  output logic      [15:0]          word_ff,
  output logic                      word_vld_ff
);
  if (PAGE_BITS >= ROM_AW || PAGE_BITS < 1) begin
    $error("page bits must be below rom address width");
  end

  logic [15:0] nxt_word;
  logic        nxt_word_vld;
  logic        pend_ff;
  logic        nxt_pend;

  // page from pc or all ones, offset from pointer
  always_comb begin
    rom_addr     = {(final_page ? {(ROM_AW-PAGE_BITS){1'b1}} : pc[ROM_AW-1:PAGE_BITS]), table_pointer};
    nxt_pend     = fetch;
    nxt_word_vld = pend_ff;
    nxt_word     = pend_ff ? rom_data : word_ff;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pend_ff     <= 1'b0;
      word_vld_ff <= 1'b0;
      word_ff     <= 16'h0000;
    end else begin
      pend_ff     <= nxt_pend;
      word_vld_ff <= nxt_word_vld;
      word_ff     <= nxt_word;
    end
  end
endmodule
`default_nettype wire

// ### core/skip_table_xor_exec.sv
/*
 * execution unit for zero-test skips, table reads, exclusive-or and nibble swap.
 * assumes the core presents the memory operand with each request on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"
module skip_table_xor_exec #(
  parameter int ROM_AW    = `ROM_AW,
  parameter int PAGE_BITS = `PAGE_BITS
) (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  // instruction request
  input  wire logic                     req_vld,
  input  wire exec_pkg::exec_req_t      req,
  input  wire logic [`DATA_W-1:0]       mem_rdata,
  input  wire logic [ROM_AW-1:0]        pc,
  input  wire logic [PAGE_BITS-1:0]     table_pointer,
  // program rom
  output logic      [ROM_AW-1:0]        rom_addr_ff,
  input  wire logic [15:0]              rom_data,
  // results
  output exec_pkg::mem_wr_t             mem_wr_ff,
  output logic      [`DATA_W-1:0]       acc_ff,
  output logic      [`DATA_W-1:0]       table_high_latch_ff,
  output logic                          zero_flag_ff,
  output logic                          discard_ff,
  output logic                          busy_ff
);
  import exec_pkg::*;

  if (PAGE_BITS >= ROM_AW || PAGE_BITS < 1) begin
    $error("page bits must be below rom address width");
  end

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DUMMY = 2'b01,
    ST_TABLE = 2'b10,
    ST_WRITE = 2'b11
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // table fetch
  logic [ROM_AW-1:0] rom_addr_c;
  logic [15:0]       word;
  logic              word_vld;
  logic              tbl_fetch;
  logic              tbl_final;

  table_rom_port #(.ROM_AW(ROM_AW), .PAGE_BITS(PAGE_BITS)) u_rom_port (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .fetch         (tbl_fetch),
    .final_page    (tbl_final),
    .pc            (pc),
    .table_pointer (table_pointer),
    .rom_addr      (rom_addr_c),
    .rom_data      (rom_data),
    .word_ff       (word),
    .word_vld_ff   (word_vld)
  );

  ////////////////////////////////////////////////////////////////////////////
  // execute
  state_t             state_ff;
  state_t             nxt_state;
  logic [`RAM_AW-1:0] tbl_addr_ff;
  logic [`RAM_AW-1:0] nxt_tbl_addr;
  logic [ROM_AW-1:0]  nxt_rom_addr;
  mem_wr_t            nxt_mem_wr;
  logic [`DATA_W-1:0] nxt_acc;
  logic [`DATA_W-1:0] nxt_table_high_latch;
  logic               nxt_zero;
  logic               nxt_discard;
  logic               nxt_busy;
  logic [`DATA_W-1:0] xres;
  logic               go;

  always_comb begin
    go           = req_vld && (state_ff == ST_IDLE);
    tbl_fetch    = go && (req.op == OP_TABLE_CUR || req.op == OP_TABLE_FINAL);
    tbl_final    = (req.op == OP_TABLE_FINAL);
    xres         = acc_ff ^ ((req.op == OP_XOR_IMM) ? req.imm : mem_rdata);
    nxt_state    = state_ff;
    nxt_tbl_addr = tbl_addr_ff;
    nxt_rom_addr = tbl_fetch ? rom_addr_c : rom_addr_ff;
    nxt_mem_wr   = '0;
    nxt_acc      = acc_ff;
    nxt_table_high_latch     = table_high_latch_ff;
    nxt_zero     = zero_flag_ff;
    nxt_discard  = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (go) begin
          unique case (req.op)
            OP_SWAP_TO_ACC: nxt_acc = {mem_rdata[3:0], mem_rdata[7:4]};
            OP_SKIP_NULL: begin
              if (mem_rdata == 8'h00) nxt_state = ST_DUMMY;
            end
            OP_COPY_SKIP_NULL: begin
              nxt_acc = mem_rdata;
              if (mem_rdata == 8'h00) nxt_state = ST_DUMMY;
            end
            OP_SKIP_BIT_CLR: begin
              if (!mem_rdata[req.bit_sel]) nxt_state = ST_DUMMY;
            end
            OP_TABLE_CUR, OP_TABLE_FINAL: begin
              nxt_state    = ST_TABLE;
              nxt_tbl_addr = req.addr;
            end
            OP_XOR_ACC, OP_XOR_IMM: begin
              nxt_acc  = xres;
              nxt_zero = (xres == 8'h00);
            end
            OP_XOR_MEM: begin
              nxt_mem_wr = '{we: 1'b1, addr: req.addr, data: xres};
              nxt_zero   = (xres == 8'h00);
            end
            default: ;
          endcase
        end
      end
      ST_DUMMY: begin
        nxt_discard = 1'b1;
        nxt_state   = ST_IDLE;
      end
      ST_TABLE: nxt_state = ST_WRITE;
      ST_WRITE: begin
        if (word_vld) begin
          nxt_mem_wr = '{we: 1'b1, addr: tbl_addr_ff, data: word[7:0]};
          nxt_table_high_latch   = word[15:8];
        end
        nxt_state = ST_IDLE;
      end
    endcase
    nxt_busy = (nxt_state != ST_IDLE);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff            <= ST_IDLE;
      tbl_addr_ff         <= '0;
      rom_addr_ff         <= '0;
      mem_wr_ff           <= '0;
      acc_ff              <= `ACC_RESET;
      table_high_latch_ff <= `TABLE_HIGH_LATCH_RESET;
      zero_flag_ff        <= 1'b0;
      discard_ff          <= 1'b0;
      busy_ff             <= 1'b0;
    end else begin
      state_ff            <= nxt_state;
      tbl_addr_ff         <= nxt_tbl_addr;
      rom_addr_ff         <= nxt_rom_addr;
      mem_wr_ff           <= nxt_mem_wr;
      acc_ff              <= nxt_acc;
      table_high_latch_ff <= nxt_table_high_latch;
      zero_flag_ff        <= nxt_zero;
      discard_ff          <= nxt_discard;
      busy_ff             <= nxt_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_skip_taken;
    busy_ff && state_ff == ST_DUMMY;
  endsequence
  sequence s_dummy_done;
    discard_ff && !busy_ff;
  endsequence

  property p_skip_two_cycles;
    @(posedge core_clk) disable iff (!resetn) s_skip_taken |=> s_dummy_done;
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip not two cycles");

  property p_noskip_one_cycle;
    @(posedge core_clk) disable iff (!resetn)
      go && req.op == OP_SKIP_NULL && mem_rdata != 8'h00 |=> !busy_ff ##1 !discard_ff;
  endproperty
  a_noskip_one_cycle: assert property (p_noskip_one_cycle) else $error("spurious skip");

  property p_skip_null;
    @(posedge core_clk) disable iff (!resetn)
      go && req.op == OP_SKIP_NULL && mem_rdata == 8'h00
      |=> busy_ff && $stable(acc_ff) && $stable(zero_flag_ff) && !mem_wr_ff.we;
  endproperty
  a_skip_null: assert property (p_skip_null) else $error("byte skip wrong");

  property p_copy_skip;
    @(posedge core_clk) disable iff (!resetn)
      go && req.op == OP_COPY_SKIP_NULL |=> acc_ff == $past(mem_rdata) && $stable(zero_flag_ff)
      && busy_ff == ($past(mem_rdata) == 8'h00);
  endproperty
  a_copy_skip: assert property (p_copy_skip) else $error("copy skip wrong");

  property p_bit_skip;
    @(posedge core_clk) disable iff (!resetn)
      go && req.op == OP_SKIP_BIT_CLR |=> busy_ff == !$past(mem_rdata[req.bit_sel]) && !mem_wr_ff.we;
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong");

  property p_table_read;
    @(posedge core_clk) disable iff (!resetn)
      tbl_fetch |=> busy_ff ##1 busy_ff ##1
        mem_wr_ff.we && mem_wr_ff.addr == $past(req.addr, 3) && $stable(zero_flag_ff) && !busy_ff
        && mem_wr_ff.data == $past(rom_data[7:0]) && table_high_latch_ff == $past(rom_data[15:8]);
  endproperty
  a_table_read: assert property (p_table_read) else $error("table read wrong");

  property p_final_page;
    @(posedge core_clk) disable iff (!resetn)
      tbl_fetch && tbl_final |=> rom_addr_ff[ROM_AW-1:PAGE_BITS] == '1;
  endproperty
  a_final_page: assert property (p_final_page) else $error("final page wrong");

  property p_xor_acc;
    @(posedge core_clk) disable iff (!resetn)
      go && (req.op == OP_XOR_ACC || req.op == OP_XOR_IMM)
      |=> acc_ff == ($past(acc_ff) ^ $past((req.op == OP_XOR_IMM) ? req.imm : mem_rdata))
      && zero_flag_ff == (acc_ff == 8'h00) && !mem_wr_ff.we;
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("xor to acc wrong");

  property p_xor_mem;
    @(posedge core_clk) disable iff (!resetn)
      go && req.op == OP_XOR_MEM |=> mem_wr_ff.we && mem_wr_ff.data == ($past(acc_ff) ^ $past(mem_rdata))
      && $stable(acc_ff) && zero_flag_ff == (mem_wr_ff.data == 8'h00);
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

  property p_swap;
    @(posedge core_clk) disable iff (!resetn)
      go && req.op == OP_SWAP_TO_ACC |=> acc_ff == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}
      && $stable(zero_flag_ff) && !mem_wr_ff.we;
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");
endmodule
`default_nettype wire

// ### testbench/exec_mem_model.sv
/*
 * partner model: data memory and program rom seen by the execution unit.
 * assumes the bench loads operands into ram and the rom answers from rom_addr.
 */
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"
module exec_mem_model (
  // clock
  input  wire logic                core_clk,
  // data memory
  input  wire exec_pkg::mem_wr_t   mem_wr,
  input  wire logic [`RAM_AW-1:0]  rd_addr,
  output logic      [`DATA_W-1:0]  rd_data,
  // program rom
  input  wire logic [`ROM_AW-1:0]  rom_addr,
  output logic      [15:0]         rom_data
);
  import exec_pkg::*;
  logic [`DATA_W-1:0] ram [0:(1<<`RAM_AW)-1];
  ////////////////////////////////////////////////////////////////
  // rom content depends on the address, so a wrong page shows
  assign rom_data = {rom_addr[7:0] ^ 8'hC3, rom_addr[13:6]};
  assign rd_data  = ram[rd_addr];
  always @(posedge core_clk) begin
    if (mem_wr.we) begin
      ram[mem_wr.addr] <= mem_wr.data;
    end
  end
endmodule
`default_nettype wire

// ### testbench/test_skip_table_xor_exec.sv
/*
 * self-checking bench: expected notes queued by the driver, checked by a monitor.
 * assumes the design package and the memory model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"
module test_skip_table_xor_exec;
  import exec_pkg::*;
  typedef struct {
    int                 due;
    logic               we, tbl, zero, disc;
    logic [`RAM_AW-1:0] wa;
    logic [`ROM_AW-1:0] ra;
    logic [7:0]         wd, acc, latch;
  } note_t;
  logic               core_clk      = 1'b0;
  logic               resetn        = 1'b0;
  logic               req_vld       = 1'b0;
  exec_req_t          req           = '0;
  logic [`ROM_AW-1:0] pc            = '0;
  logic [7:0]         table_pointer = '0;
  logic [`ROM_AW-1:0] rom_addr_ff;
  logic [15:0]        rom_data;
  logic [7:0]         mem_rdata, acc_ff, table_high_latch_ff;
  mem_wr_t            mem_wr_ff;
  logic               zero_flag_ff, discard_ff, busy_ff;
  note_t              notes[$];
  int                 cyc = 0, mismatches = 0, n_compared = 0;
  logic [7:0]         e_acc = 8'h00, e_latch = 8'h00;
  logic               e_zero = 1'b0;

  skip_table_xor_exec skip_table_xor_exec_inst (.core_clk(core_clk), .resetn(resetn),
    .req_vld(req_vld), .req(req), .mem_rdata(mem_rdata), .pc(pc),
    .table_pointer(table_pointer), .rom_addr_ff(rom_addr_ff), .rom_data(rom_data),
    .mem_wr_ff(mem_wr_ff), .acc_ff(acc_ff), .table_high_latch_ff(table_high_latch_ff),
    .zero_flag_ff(zero_flag_ff), .discard_ff(discard_ff), .busy_ff(busy_ff));
  exec_mem_model exec_mem_model_inst (.core_clk(core_clk), .mem_wr(mem_wr_ff),
    .rd_addr(req.addr), .rd_data(mem_rdata), .rom_addr(rom_addr_ff), .rom_data(rom_data));

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////
  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp_val(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // drive one instruction at a falling edge and note its outcome
  task automatic issue(input exec_op_t op, input logic [7:0] m, input logic [7:0] imm);
    note_t              n;
    exec_req_t          r;
    int                 lat;
    logic [`ROM_AW-1:0] a;
    r = '{op: op, addr: 12'($urandom), bit_sel: 3'($urandom), imm: imm};
    pc = 14'($urandom);
    table_pointer = 8'($urandom);
    exec_mem_model_inst.ram[r.addr] = m;
    n = '{due: 0, we: 1'b0, tbl: 1'b0, zero: 1'b0, disc: 1'b0, wa: r.addr, ra: '0,
          wd: 8'h00, acc: 8'h00, latch: 8'h00};
    lat = 1;
    case (op)
      OP_SWAP_TO_ACC:    e_acc = {m[3:0], m[7:4]};
      OP_SKIP_NULL:      n.disc = (m == 8'h00);
      OP_COPY_SKIP_NULL: begin
        e_acc = m;
        n.disc = (m == 8'h00);
      end
      OP_SKIP_BIT_CLR:   n.disc = ~m[r.bit_sel];
      OP_TABLE_CUR, OP_TABLE_FINAL: begin
        a = {(op == OP_TABLE_CUR) ? pc[13:8] : 6'h3F, table_pointer};
        n.tbl = 1'b1;
        n.ra = a;
        n.we = 1'b1;
        n.wd = a[13:6];
        e_latch = a[7:0] ^ 8'hC3;
        lat = 3;
      end
      OP_XOR_ACC: begin
        e_acc = e_acc ^ m;
        e_zero = (e_acc == 8'h00);
      end
      OP_XOR_MEM: begin
        n.we = 1'b1;
        n.wd = e_acc ^ m;
        e_zero = (n.wd == 8'h00);
      end
      default: begin
        e_acc = e_acc ^ imm;
        e_zero = (e_acc == 8'h00);
      end
    endcase
    if (n.disc) lat = 2;
    n.acc = e_acc;
    n.latch = e_latch;
    n.zero = e_zero;
    n.due = cyc + lat;
    notes.push_back(n);
    req = r;
    req_vld = 1'b1;
    @(negedge core_clk);
    if (lat > 1) begin
      // request held up while busy: must be ignored
      req.op = OP_XOR_IMM;
      req.imm = 8'hFF;
      repeat (lat - 1) @(negedge core_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // monitor: oldest note checked when its result is due
  always @(posedge core_clk) begin
    note_t n;
    #1;
    if (notes.size() > 0 && notes[0].due == cyc) begin
      n = notes.pop_front();
      cmp_bit("write strobe", n.we, mem_wr_ff.we);
      if (n.we) begin
        cmp_val("write addr", 16'(n.wa), 16'(mem_wr_ff.addr));
        cmp_val("write data", 16'(n.wd), 16'(mem_wr_ff.data));
      end
      if (n.tbl) cmp_val("rom addr", 16'(n.ra), 16'(rom_addr_ff));
      cmp_val("acc", 16'(n.acc), 16'(acc_ff));
      cmp_val("latch", 16'(n.latch), 16'(table_high_latch_ff));
      cmp_bit("zero", n.zero, zero_flag_ff);
      cmp_bit("discard", n.disc, discard_ff);
      cmp_bit("busy", 1'b0, busy_ff);
    end else begin
      cmp_bit("idle strobe", 1'b0, mem_wr_ff.we);
      cmp_bit("idle discard", 1'b0, discard_ff);
    end
  end

  initial begin
    #50000;
    mismatches++;
    conclude();
  end

  initial begin
    exec_op_t   op;
    logic [7:0] m, imm;
    void'($urandom(62));
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    for (int i = 0; i < 90; i++) begin
      op = exec_op_t'(4'(i < 18 ? 1 + i % 9 : 1 + $urandom % 9));
      m = 8'($urandom);
      imm = 8'($urandom);
      if ($urandom % 3 == 0) begin
        m = (op == OP_XOR_ACC || op == OP_XOR_MEM) ? e_acc : 8'h00;
        imm = e_acc;
      end
      issue(op, m, imm);
    end
    req_vld = 1'b0;
    repeat (5) @(negedge core_clk);
    conclude();
  end
endmodule
`default_nettype wire
